// [core/dpdiag_link_if.sv]
/*
 Link between the slave end and the master end.
 Both ends run on the same clock; all signals are driven from flops.
*/
`timescale 1ns/1ns
`default_nettype none
interface dpdiag_link_if;
   logic       diag_req;
   logic       d_valid;
   logic [7:0] d_data;
   logic       d_last;
   logic       ack_valid;
   logic [4:0] ack_seq;

   modport slave
   (
      input  diag_req,
      output d_valid,
      output d_data,
      output d_last,
      input  ack_valid,
      input  ack_seq
   );
   modport master
   (
      output diag_req,
      input  d_valid,
      input  d_data,
      input  d_last,
      output ack_valid,
      output ack_seq
   );
endinterface
`default_nettype wire

// [core/dpdiag_master_end.sv]
/*
 Master end: requests diagnostics, stores the received frame,
 repeats polls while static diagnostics stand without a parameter request and acknowledges interrupts.
 Assumes the slave end sits on the same mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module dpdiag_master_end
(
   // Clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        ce,
   // Link
   dpdiag_link_if.master    lnk,
   // User request
   input  wire logic        poll,
   input  wire logic        deactivated,
   output logic             busy,
   output logic             frame_done,
   // Received fields
   output logic [7:0]       stat1,
   output logic [7:0]       stat2,
   output logic [7:0]       stat3,
   output logic [7:0]       master_addr,
   output logic [15:0]      ident,
   output logic [7:0]       dev_hdr,
   output logic [7:0]       dev_type,
   output logic [7:0]       dev_slot,
   output logic [7:0]       dev_spec,
   output logic             need_param,
   output logic             add_ack_seen,
   // Module data read
   input  wire logic [5:0]  mod_rd_idx,
   output logic [7:0]       mod_rd_data
);
   dpdiag_pkg::dpdiag_state_t state_q;
   logic [7:0] mod_mem [0:58];
   logic [6:0] rx_idx_q;
   logic       repoll_q;
   logic       start;

   assign start = (poll || repoll_q) && (state_q == dpdiag_pkg::DPD_IDLE);

   // ==========================================
   // Request sequencer
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q      <= dpdiag_pkg::DPD_IDLE;
         lnk.diag_req <= 1'b0;
         busy         <= 1'b0;
      end
      else if (ce)
      begin
         lnk.diag_req <= start;
         case (state_q)
            dpdiag_pkg::DPD_IDLE:
               if (start)
               begin
                  state_q <= dpdiag_pkg::DPD_BUSY;
                  busy    <= 1'b1;
               end
            dpdiag_pkg::DPD_BUSY:
               if (lnk.d_valid && lnk.d_last)
               begin
                  state_q <= dpdiag_pkg::DPD_IDLE;
                  busy    <= 1'b0;
               end
            default: state_q <= dpdiag_pkg::DPD_IDLE;
         endcase
      end
   end

   // ==========================================
   // Receive store
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_idx_q    <= 7'h00;
         stat1       <= 8'h00;
         stat2       <= 8'h00;
         stat3       <= 8'h00;
         master_addr <= 8'h00;
         ident       <= 16'h0000;
         dev_hdr     <= 8'h00;
         dev_type    <= 8'h00;
         dev_slot    <= 8'h00;
         dev_spec    <= 8'h00;
      end
      else if (ce)
      begin
         if (start)
            dev_hdr <= 8'h00;
         if (lnk.d_valid)
         begin
            rx_idx_q <= lnk.d_last ? 7'h00 : rx_idx_q + 7'h01;
            case (rx_idx_q)
               dpdiag_pkg::IDX_ST1:   stat1 <= lnk.d_data;
               dpdiag_pkg::IDX_ST2:   stat2 <= {deactivated, lnk.d_data[6:0]};
               dpdiag_pkg::IDX_ST3:   stat3 <= lnk.d_data;
               dpdiag_pkg::IDX_MADDR: master_addr <= lnk.d_data;
               dpdiag_pkg::IDX_ID_LO: ident[7:0] <= lnk.d_data;
               dpdiag_pkg::IDX_ID_HI: ident[15:8] <= lnk.d_data;
               dpdiag_pkg::IDX_HDR:   dev_hdr <= lnk.d_data;
               dpdiag_pkg::IDX_TYPE:  dev_type <= lnk.d_data;
               dpdiag_pkg::IDX_SLOT:  dev_slot <= lnk.d_data;
               dpdiag_pkg::IDX_SPEC:  dev_spec <= lnk.d_data;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (ce && lnk.d_valid && rx_idx_q >= dpdiag_pkg::IDX_MOD)
         mod_mem[6'(rx_idx_q - dpdiag_pkg::IDX_MOD)] <= lnk.d_data;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         mod_rd_data <= 8'h00;
      else if (ce)
         mod_rd_data <= (mod_rd_idx < 6'h3b) ? mod_mem[mod_rd_idx] : 8'h00;
   end

   // ==========================================
   // Frame end: repoll and acknowledge
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         frame_done    <= 1'b0;
         repoll_q      <= 1'b0;
         need_param    <= 1'b0;
         add_ack_seen  <= 1'b0;
         lnk.ack_valid <= 1'b0;
         lnk.ack_seq   <= 5'h00;
      end
      else if (ce)
      begin
         frame_done    <= lnk.d_valid && lnk.d_last;
         lnk.ack_valid <= 1'b0;
         if (start)
            repoll_q <= 1'b0;
         if (lnk.d_valid && lnk.d_last)
         begin
            need_param <= stat2[dpdiag_pkg::ST2_PRM_REQ];
            // Parameter request takes precedence over static repolling.
            repoll_q   <= stat2[dpdiag_pkg::ST2_STATIC] && !stat2[dpdiag_pkg::ST2_PRM_REQ];
            if (dev_hdr != 8'h00 && !dev_type[dpdiag_pkg::TYPE_VAR])
            begin
               lnk.ack_valid <= 1'b1;
               // Specifier is this last byte, not yet stored
               lnk.ack_seq   <= lnk.d_data[7:3];
               add_ack_seen  <= lnk.d_data[dpdiag_pkg::SPEC_ADD_ACK];
            end
         end
      end
   end
endmodule
`default_nettype wire

// [core/dpdiag_mod_pack.sv]
/*
 Packs per-slot two-bit status into one module-status byte.
 Combinational; the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
module dpdiag_mod_pack
(
   // Slot status
   input  wire logic [2*dpdiag_pkg::MAX_SLOTS-1:0] slot_status,
   input  wire logic [7:0]                         n_slots,
   // Byte select
   input  wire logic [5:0]                         byte_idx,
   output logic      [7:0]                         mod_byte
);
   always_comb
   begin
      logic [9:0] slot;
      mod_byte = 8'h00;
      slot     = 10'h000;
      for (int k = 0; k < 4; k++)
      begin
         slot = {2'h0, byte_idx, 2'h0} + 10'(k);
         if ((slot < {2'h0, n_slots}) && (slot < 10'(dpdiag_pkg::MAX_SLOTS)))
            mod_byte[2*k +: 2] = slot_status[2*slot +: 2];
      end
   end
endmodule
`default_nettype wire

// [core/dpdiag_pkg.sv]
/*
 Constants shared by both ends of the slave diagnostics link.
 Assumes a single clock domain and byte-wide transfer.
*/
`default_nettype none
package dpdiag_pkg;
   // ==========================================
   // Frame layout
   localparam int unsigned STD_BYTES    = 6;
   localparam logic [5:0]  DEV_HDR_LEN  = 6'h04;
   localparam logic [5:0]  MOD_MAX      = 6'h3b;
   localparam logic [6:0]  IDX_ST1      = 7'h00;
   localparam logic [6:0]  IDX_ST2      = 7'h01;
   localparam logic [6:0]  IDX_ST3      = 7'h02;
   localparam logic [6:0]  IDX_MADDR    = 7'h03;
   localparam logic [6:0]  IDX_ID_LO    = 7'h04;
   localparam logic [6:0]  IDX_ID_HI    = 7'h05;
   localparam logic [6:0]  IDX_HDR      = 7'h06;
   localparam logic [6:0]  IDX_TYPE     = 7'h07;
   localparam logic [6:0]  IDX_SLOT     = 7'h08;
   localparam logic [6:0]  IDX_SPEC     = 7'h09;
   localparam logic [6:0]  IDX_MOD      = 7'h0a;
   // ==========================================
   // Field positions
   localparam int unsigned ST2_DEACT    = 7;
   localparam int unsigned ST2_SYNC     = 5;
   localparam int unsigned ST2_FREEZE   = 4;
   localparam int unsigned ST2_WDOG     = 3;
   localparam int unsigned ST2_FROM_SLV = 2;
   localparam int unsigned ST2_STATIC   = 1;
   localparam int unsigned ST2_PRM_REQ  = 0;
   localparam int unsigned ST3_OVF      = 7;
   localparam int unsigned TYPE_VAR     = 7;
   localparam int unsigned SPEC_ADD_ACK = 2;
   localparam logic [1:0]  HDR_MOD_ID   = 2'h0;
   // ==========================================
   // Codes and reset values
   localparam logic [7:0]  MADDR_NONE   = 8'hff;
   localparam logic [6:0]  IRQ_DIAG     = 7'h01;
   localparam logic [6:0]  IRQ_STATUS   = 7'h05;
   localparam logic [6:0]  STAT_INFO    = 7'h01;
   localparam logic [6:0]  STAT_MOD     = 7'h02;
   localparam logic [1:0]  SLOT_OK      = 2'h0;
   localparam logic [1:0]  SLOT_FAULT   = 2'h1;
   localparam logic [1:0]  SLOT_WRONG   = 2'h2;
   localparam logic [1:0]  SLOT_NONE    = 2'h3;
   localparam logic [1:0]  SSPEC_RSVD   = 2'h3;
   localparam int unsigned MAX_SLOTS    = 236;
   localparam int unsigned SEQ_W        = 5;

   typedef enum logic [1:0] {
      DPD_IDLE = 2'b00,
      DPD_BUSY = 2'b01
   } dpdiag_state_t;
endpackage
`default_nettype wire

// [core/dpdiag_slave_end.sv]
/*
 Slave end: builds and streams the diagnostics frame on request,
 holds one pending interrupt until the master acknowledges it or a newer status interrupt replaces a pending status one.
 Assumes all user inputs are synchronous to mclk.
*/
// What this block does
// - Six standard bytes lead every frame
// - Master reports deactivated slave in bit 7
// - Sync, freeze, watchdog bits reflect slave modes
// - Station status 2 bit 2 always one
// - Master repolls while static bit set
// - Parameter request bit outranks static bit
// - Overflow in status 3 bit 7
// - Master address, 255 when unconfigured
// - Ident low byte 4, high byte 5
// - Header upper bits are 00
// - Header length counts header byte
// - Interrupt type: bit7 clear, kind code
// - Newer status interrupt replaces pending status one
// - Status type: bit7 set, status code
// - Slot number, zero means whole device
// - Specifier bits 7..3 carry sequence value
// - Bit 2 flags extra acknowledge write
// - Interrupt specifier two-bit fault code
// - Status specifier code, reserved bits zero
// - Two status bits per slot from byte 4
// - Absent slot pairs are zero
// - Slot status two-bit encoding
// - Master acknowledges every interrupt
`timescale 1ns/1ns
`default_nettype none
module dpdiag_slave_end
(
   // Clock, reset, enable
   input  wire logic                               mclk,
   input  wire logic                               nrst,
   input  wire logic                               ce,
   // Link
   dpdiag_link_if.slave                            lnk,
   // Station status
   input  wire logic                               sync_mode,
   input  wire logic                               freeze_mode,
   input  wire logic                               wdog_on,
   input  wire logic                               static_diag,
   input  wire logic                               param_req,
   input  wire logic                               diag_overflow,
   input  wire logic                               cfg_valid,
   input  wire logic [7:0]                         cfg_master_addr,
   input  wire logic [15:0]                        slave_ident,
   // Interrupt post
   input  wire logic                               irq_post,
   input  wire logic [6:0]                         irq_kind,
   input  wire logic [7:0]                         irq_slot,
   input  wire logic                               irq_add_ack,
   input  wire logic [1:0]                         irq_spec,
   output logic                                    irq_pending,
   output logic                                    irq_drop,
   // Status report
   input  wire logic                               stat_en,
   input  wire logic [6:0]                         stat_code,
   input  wire logic [7:0]                         stat_slot,
   input  wire logic [1:0]                         stat_spec,
   input  wire logic [2*dpdiag_pkg::MAX_SLOTS-1:0] slot_status,
   input  wire logic [7:0]                         n_slots
);
   // ==========================================
   // Declarations
   dpdiag_pkg::dpdiag_state_t state_q;
   logic [6:0] idx_q;
   logic [6:0] flen_q;
   logic [5:0] dlen_q;
   logic       use_irq_q;
   logic       pend_q;
   logic [6:0] pkind_q;
   logic [7:0] pslot_q;
   logic       pack_q;
   logic [1:0] pspec_q;
   logic [4:0] pseq_q;
   logic [4:0] seq_cnt_q;
   logic       ack_hit;
   logic       post_ok;
   logic [5:0] mod_n;
   logic [5:0] mod_idx;
   logic [7:0] mod_byte;
   logic [7:0] cur;

   // ==========================================
   // Pending interrupt
   // Acknowledge of the pending sequence frees the slot.
   assign ack_hit = lnk.ack_valid && pend_q && (lnk.ack_seq == pseq_q);
   // A newer status interrupt may overwrite a pending status one.
   assign post_ok = irq_post && (!pend_q || ack_hit
                    || (pkind_q == dpdiag_pkg::IRQ_STATUS && irq_kind == dpdiag_pkg::IRQ_STATUS));

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pend_q    <= 1'b0;
         pkind_q   <= 7'h00;
         pslot_q   <= 8'h00;
         pack_q    <= 1'b0;
         pspec_q   <= 2'h0;
         pseq_q    <= 5'h00;
         seq_cnt_q <= 5'h00;
         irq_drop  <= 1'b0;
      end
      else if (ce)
      begin
         irq_drop <= irq_post && !post_ok;
         // Set wins over an acknowledge in the same cycle.
         if (post_ok)
         begin
            pend_q    <= 1'b1;
            pkind_q   <= irq_kind;
            pslot_q   <= irq_slot;
            pack_q    <= irq_add_ack;
            pspec_q   <= irq_spec;
            pseq_q    <= seq_cnt_q;
            seq_cnt_q <= seq_cnt_q + 5'h01;
         end
         else if (ack_hit)
            pend_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         irq_pending <= 1'b0;
      else if (ce)
         irq_pending <= post_ok || (pend_q && !ack_hit);
   end

   // ==========================================
   // Frame length
   always_comb
   begin
      mod_n = 6'h00;
      if (stat_code == dpdiag_pkg::STAT_MOD)
      begin
         if (n_slots > 8'(4 * 59 - 3))
            mod_n = dpdiag_pkg::MOD_MAX;
         else
            mod_n = 6'((n_slots + 8'h03) >> 2);
      end
   end

   // ==========================================
   // Byte assembly
   assign mod_idx = 6'(idx_q - dpdiag_pkg::IDX_MOD);

   dpdiag_mod_pack u_pack
   (
      .slot_status (slot_status),
      .n_slots     (n_slots),
      .byte_idx    (mod_idx),
      .mod_byte    (mod_byte)
   );

   always_comb
   begin
      cur = 8'h00;
      case (idx_q)
         dpdiag_pkg::IDX_ST1:   cur = 8'h00;
         dpdiag_pkg::IDX_ST2:
         begin
            cur = 8'h00;
            cur[dpdiag_pkg::ST2_SYNC]     = sync_mode;
            cur[dpdiag_pkg::ST2_FREEZE]   = freeze_mode;
            cur[dpdiag_pkg::ST2_WDOG]     = wdog_on;
            cur[dpdiag_pkg::ST2_FROM_SLV] = 1'b1;
            cur[dpdiag_pkg::ST2_STATIC]   = static_diag;
            cur[dpdiag_pkg::ST2_PRM_REQ]  = param_req;
         end
         dpdiag_pkg::IDX_ST3:   cur = {diag_overflow, 7'h00};
         dpdiag_pkg::IDX_MADDR: cur = cfg_valid ? cfg_master_addr : dpdiag_pkg::MADDR_NONE;
         dpdiag_pkg::IDX_ID_LO: cur = slave_ident[7:0];
         dpdiag_pkg::IDX_ID_HI: cur = slave_ident[15:8];
         dpdiag_pkg::IDX_HDR:   cur = {dpdiag_pkg::HDR_MOD_ID, dlen_q};
         dpdiag_pkg::IDX_TYPE:  cur = use_irq_q ? {1'b0, pkind_q} : {1'b1, stat_code};
         dpdiag_pkg::IDX_SLOT:  cur = use_irq_q ? pslot_q : stat_slot;
         dpdiag_pkg::IDX_SPEC:
         begin
            if (use_irq_q)
               cur = {pseq_q, pack_q, pspec_q};
            else if (stat_spec == dpdiag_pkg::SSPEC_RSVD)
               cur = 8'h00;
            else
               cur = {6'h00, stat_spec};
         end
         default:               cur = mod_byte;
      endcase
   end

   // ==========================================
   // Frame sequencer
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q   <= dpdiag_pkg::DPD_IDLE;
         idx_q     <= 7'h00;
         flen_q    <= 7'h00;
         dlen_q    <= 6'h00;
         use_irq_q <= 1'b0;
      end
      else if (ce)
      begin
         case (state_q)
            dpdiag_pkg::DPD_IDLE:
            begin
               idx_q <= 7'h00;
               if (lnk.diag_req)
               begin
                  state_q   <= dpdiag_pkg::DPD_BUSY;
                  use_irq_q <= pend_q;
                  if (pend_q)
                  begin
                     dlen_q <= dpdiag_pkg::DEV_HDR_LEN;
                     flen_q <= 7'(dpdiag_pkg::STD_BYTES + dpdiag_pkg::DEV_HDR_LEN);
                  end
                  else if (stat_en)
                  begin
                     dlen_q <= dpdiag_pkg::DEV_HDR_LEN + mod_n;
                     flen_q <= 7'(dpdiag_pkg::STD_BYTES + dpdiag_pkg::DEV_HDR_LEN + mod_n);
                  end
                  else
                  begin
                     dlen_q <= 6'h00;
                     flen_q <= 7'(dpdiag_pkg::STD_BYTES);
                  end
               end
            end
            dpdiag_pkg::DPD_BUSY:
            begin
               idx_q <= idx_q + 7'h01;
               if (idx_q == flen_q - 7'h01)
                  state_q <= dpdiag_pkg::DPD_IDLE;
            end
            default: state_q <= dpdiag_pkg::DPD_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         lnk.d_valid <= 1'b0;
         lnk.d_data  <= 8'h00;
         lnk.d_last  <= 1'b0;
      end
      else if (ce)
      begin
         lnk.d_valid <= state_q == dpdiag_pkg::DPD_BUSY;
         lnk.d_data  <= (state_q == dpdiag_pkg::DPD_BUSY) ? cur : 8'h00;
         lnk.d_last  <= (state_q == dpdiag_pkg::DPD_BUSY) && (idx_q == flen_q - 7'h01);
      end
   end
endmodule
`default_nettype wire

// [tb/dpdiag_sva.sv]
/*
 Link checker for the diagnostics frame between slave and master ends.
 Instantiated by tb beside the link interface; single clock mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module dpdiag_sva
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // Link
   input  wire logic       diag_req,
   input  wire logic       d_valid,
   input  wire logic [7:0] d_data,
   input  wire logic       d_last,
   input  wire logic       ack_valid,
   input  wire logic [4:0] ack_seq
);
   logic [6:0] idx_q;
   logic [5:0] len_q;
   logic       stv_q;

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   // ==========================================
   // Frame position, header and variant capture
   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
         idx_q <= 7'h00;
      else if (d_valid)
         idx_q <= d_last ? 7'h00 : idx_q + 7'h01;

   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
         len_q <= 6'h00;
      else if (d_valid && idx_q == 7'h06)
         len_q <= d_data[5:0];

   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
         stv_q <= 1'b0;
      else if (d_valid && idx_q == 7'h07)
         stv_q <= d_data[7];

   // ==========================================
   // Link properties
   a_answer_delay: assert property ($rose(d_valid) |-> $past(diag_req, 2))
      else $error("frame start not two cycles after request");
   a_from_slave: assert property (d_valid && idx_q == 7'h01 |-> d_data[2] && !d_data[6])
      else $error("status 2 origin or reserved bit wrong");
   a_st3_reserved: assert property (d_valid && idx_q == 7'h02 |-> d_data[6:0] == 7'h00)
      else $error("status 3 reserved bits set");
   a_hdr_top: assert property (d_valid && idx_q == 7'h06 |-> d_data[7:6] == 2'h0)
      else $error("header top bits not zero");
   a_hdr_length: assert property (d_last && idx_q > 7'h06 |-> idx_q == {1'b0, len_q} + 7'h05)
      else $error("header length disagrees with frame");
   a_std_length: assert property (d_last |-> idx_q == 7'h05 || idx_q >= 7'h09)
      else $error("frame length not six or device block");
   a_frame_run: assert property (d_valid && !d_last |=> d_valid)
      else $error("gap inside frame");
   a_last_ends: assert property (d_last |=> !d_valid)
      else $error("valid after last byte");
   a_stat_spec: assert property (d_valid && idx_q == 7'h09 && stv_q |-> d_data[7:2] == 6'h00)
      else $error("status specifier reserved bits set");
   a_ack_after: assert property (ack_valid |-> $past(d_last))
      else $error("acknowledge not right after frame");
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
 Self-checking bench: both ends joined by the link interface.
 A model from integers compares every frame byte and acknowledge.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic         mclk, nrst, poll, deactivated, cfg_valid, stat_en;
   logic         irq_post, irq_add_ack, frame_done, need_param, irq_pending, irq_drop, add_ack_seen;
   logic [5:0]   sb, mod_rd_idx;
   logic [7:0]   cfg_master_addr, irq_slot, stat_slot, n_slots, stat2, stat3, master_addr, mod_rd_data;
   logic [15:0]  slave_ident, ident;
   logic [6:0]   irq_kind, stat_code;
   logic [1:0]   irq_spec, stat_spec;
   logic [471:0] slot_status;
   logic         m_pend, m_drop, m_aa;
   logic [6:0]   m_kind;
   logic [7:0]   m_slot;
   logic [1:0]   m_spec;
   logic [4:0]   m_seq, m_cnt;
   int           n_errors, samples_checked, seed, idx, len, nfr, cyc, i, j, n;

   dpdiag_link_if lnk();

   dpdiag_slave_end i_dpdiag_slave_end (.mclk(mclk), .nrst(nrst), .ce(1'b1), .lnk(lnk),
      .sync_mode(sb[5]), .freeze_mode(sb[4]), .wdog_on(sb[3]), .diag_overflow(sb[2]),
      .static_diag(sb[1]), .param_req(sb[0]), .cfg_valid(cfg_valid),
      .cfg_master_addr(cfg_master_addr), .slave_ident(slave_ident), .irq_post(irq_post),
      .irq_kind(irq_kind), .irq_slot(irq_slot), .irq_add_ack(irq_add_ack), .irq_spec(irq_spec),
      .irq_pending(irq_pending), .irq_drop(irq_drop), .stat_en(stat_en), .stat_code(stat_code),
      .stat_slot(stat_slot), .stat_spec(stat_spec), .slot_status(slot_status), .n_slots(n_slots));

   dpdiag_master_end i_dpdiag_master_end (.mclk(mclk), .nrst(nrst), .ce(1'b1), .lnk(lnk),
      .poll(poll), .deactivated(deactivated), .busy(), .frame_done(frame_done), .stat1(),
      .stat2(stat2), .stat3(stat3), .master_addr(master_addr), .ident(ident), .dev_hdr(),
      .dev_type(), .dev_slot(), .dev_spec(), .need_param(need_param), .add_ack_seen(add_ack_seen),
      .mod_rd_idx(mod_rd_idx), .mod_rd_data(mod_rd_data));

   dpdiag_sva i_dpdiag_sva (.mclk(mclk), .nrst(nrst), .diag_req(lnk.diag_req),
      .d_valid(lnk.d_valid), .d_data(lnk.d_data), .d_last(lnk.d_last),
      .ack_valid(lnk.ack_valid), .ack_seq(lnk.ack_seq));

   // ==========================================
   // Model and compare helpers
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   function automatic int flen();
      if (m_pend)
         return 10;
      if (!stat_en)
         return 6;
      return stat_code == 7'h02 ? 10 + (n_slots + 3) / 4 : 10;
   endfunction

   function automatic logic [7:0] eb(input int k);
      int         s;
      logic [7:0] b;
      b = 8'h00;
      case (k)
         0: b = 8'h00;
         1: b = {2'h0, sb[5:3], 1'b1, sb[1:0]};
         2: b = {sb[2], 7'h00};
         3: b = cfg_valid ? cfg_master_addr : 8'hff;
         4: b = slave_ident[7:0];
         5: b = slave_ident[15:8];
         6: b = 8'(len - 6);
         7: b = m_pend ? {1'b0, m_kind} : {1'b1, stat_code};
         8: b = m_pend ? m_slot : stat_slot;
         9: b = m_pend ? {m_seq, m_aa, m_spec} : {6'h00, (stat_spec == 2'h3 ? 2'h0 : stat_spec)};
         default:
            for (int q = 0; q < 4; q++)
            begin
               s = 4 * (k - 10) + q + 1;
               if (s <= n_slots)
                  b[2*q +: 2] = slot_status[2*s-1 -: 2];
            end
      endcase
      return b;
   endfunction

   always @(posedge mclk)
      if (!nrst)
      begin
         idx = 0;
         m_pend = 1'b0;
         m_cnt = 5'h00;
         nfr = 0;
      end
      else
      begin
         if (lnk.ack_valid)
         begin
            chk(lnk.ack_seq, m_seq);
            m_pend = 1'b0;
         end
         m_drop = 1'b0;
         if (irq_post)
         begin
            m_drop = m_pend && !(m_kind == 7'h05 && irq_kind == 7'h05);
            if (!m_drop)
            begin
               {m_pend, m_kind, m_slot, m_aa, m_spec, m_seq} = {1'b1, irq_kind, irq_slot, irq_add_ack, irq_spec, m_cnt};
               m_cnt = m_cnt + 5'h01;
            end
         end
         if (lnk.d_valid)
         begin
            if (idx == 0)
               len = flen();
            chk(lnk.d_data, eb(idx));
            chk(lnk.d_last, idx == len - 1);
            nfr += lnk.d_last;
            idx = lnk.d_last ? 0 : idx + 1;
         end
      end

   // ==========================================
   // Stimulus tasks
   task automatic frame(input bit req);
      int         k;
      logic [7:0] e;
      if (req)
      begin
         @(posedge mclk) poll <= 1'b1;
         @(posedge mclk) poll <= 1'b0;
      end
      k = 0;
      @(negedge mclk);
      while (frame_done !== 1'b1 && k < 300)
      begin
         @(negedge mclk);
         k++;
      end
      chk(k < 300, 1'b1);
      @(negedge mclk);
      e = eb(1);
      chk(stat2, {deactivated, e[6:0]});
      chk(master_addr, eb(3));
      chk(stat3, eb(2));
      chk(ident, slave_ident);
      chk(need_param, sb[0]);
      chk(irq_pending, m_pend);
   endtask

   task automatic post(input logic [6:0] k);
      @(posedge mclk);
      irq_post <= 1'b1;
      irq_kind <= k;
      {irq_slot, irq_add_ack, irq_spec} <= 11'($random(seed));
      @(posedge mclk) irq_post <= 1'b0;
      @(negedge mclk);
      chk(irq_drop, m_drop);
      chk(irq_pending, 1'b1);
   endtask

   task automatic summarize();
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         summarize();
      end
   end

   // ==========================================
   // Main sequence
   initial
   begin
      {nrst, poll, deactivated, cfg_valid, stat_en, irq_post, irq_add_ack} = 7'h00;
      {sb, mod_rd_idx, cfg_master_addr, irq_slot, stat_slot, n_slots} = 44'h0;
      {slave_ident, irq_kind, stat_code, irq_spec, stat_spec, slot_status} = 504'h0;
      {n_errors, samples_checked, cyc} = 96'h0;
      seed = 96;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      for (i = 0; i < 6; i++)
      begin
         @(posedge mclk);
         sb <= 6'($random(seed)) & 6'h3c;
         cfg_valid <= i[0];
         cfg_master_addr <= 8'($random(seed));
         slave_ident <= 16'($random(seed));
         deactivated <= i[1];
         frame(1'b1);
      end
      for (i = 1; i < 8; i++)
      begin
         post(i < 7 ? 7'(i) : 7'h20);
         frame(1'b1);
         chk(add_ack_seen, m_aa);
      end
      post(7'h01);
      post(7'h02);
      frame(1'b1);
      post(7'h05);
      post(7'h05);
      frame(1'b1);
      for (i = 0; i < 4; i++)
      begin
         @(posedge mclk);
         stat_en <= 1'b1;
         for (j = 0; j < 236; j++)
            slot_status[2*j +: 2] <= 2'($random(seed));
         n_slots <= i == 3 ? 8'hec : i == 0 ? 8'h00 : 8'($unsigned($random(seed)) % 236);
         stat_code <= i == 1 ? 7'h01 : 7'h02;
         stat_spec <= 2'(i);
         stat_slot <= 8'(i);
         frame(1'b1);
         for (j = 0; j < len - 10; j++)
         begin
            @(posedge mclk) mod_rd_idx <= 6'(j);
            @(posedge mclk);
            @(negedge mclk);
            chk(mod_rd_data, eb(10 + j));
         end
      end
      @(posedge mclk);
      stat_en <= 1'b0;
      sb <= 6'h02;
      n = nfr;
      frame(1'b1);
      @(posedge mclk) sb <= 6'h00;
      frame(1'b0);
      chk(16'(nfr - n), 16'h0002);
      @(posedge mclk) sb <= 6'h03;
      n = nfr;
      frame(1'b1);
      repeat (40) @(negedge mclk);
      chk(16'(nfr - n), 16'h0001);
      summarize();
   end
endmodule
`default_nettype wire
